//--- rtp_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the reload timer.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef RTP_MAP_SVH
`define RTP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RTP_ADDR_MODE 8'hD5
`define RTP_ADDR_FLAGS 8'hD6
`define RTP_ADDR_CEP 8'hD7
`define RTP_ADDR_RELOAD 8'hD9
`define RTP_ADDR_COMPARE 8'hDA
`define RTP_ADDR_LOAD 8'hDB

// ----------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------
`define RTP_MC_LOAD 7
`define RTP_MC_TEN 6
`define RTP_MC_PWM_OUTPUT_ENABLE 5
`define RTP_MC_EIE 4
`define RTP_MC_COMPARE_IRQ_ENABLE 3
`define RTP_MC_OVERFLOW_IRQ_ENABLE 2

// ----------------------------------------------------------------
// Status flag fields
// ----------------------------------------------------------------
`define RTP_SF_EF 2
`define RTP_SF_CPF 1
`define RTP_SF_OVF 0

// ----------------------------------------------------------------
// Clock, edge and prescale fields
// ----------------------------------------------------------------
`define RTP_CE_SL1 3
`define RTP_CE_SL0 2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define RTP_MODE_RST 8'h00
`define RTP_CEP_RST 8'h00
`define RTP_DIV3_LAST 2'h2

`endif

//--- rtp_pkg.sv
/*
  Types shared by the reload timer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rtp_pkg;

  typedef enum logic [1:0]
  {
    RTP_AUTO_RELOAD,
    RTP_CAPTURE,
    RTP_CAPTURE_RESET,
    RTP_EXT_LOAD
  } rtp_mode_t;

  typedef enum logic [1:0]
  {
    RTP_CLK_INT,
    RTP_CLK_DIV3,
    RTP_CLK_PIN,
    RTP_CLK_RSVD
  } rtp_clk_t;

endpackage

//--- rtp_edge_det.sv
/*
  Two-stage synchroniser with rising and falling edge detection for one pin.
  Assumes the pin is asynchronous to clk_i.
*/
module rtp_edge_det
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic sync;
  logic prev;

  // ----------------------------------------------------------------
  // Synchroniser and edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;

endmodule

//--- rtp_timer.sv
/*
  Auto-reload timer with 7-bit prescaler, compare, capture and PWM output.
  Assumes a register master on clk_i with one-cycle strobes and one-cycle-late read data.
*/
// Decided for this implementation: the plain strobed port.
`include "rtp_map.svh"

// Overview of operation
// - Counter increments on each prescaler tick
// - Auto-reload overflow reloads counter, sets PWM
// - Compare match clears PWM, sets compare flag
// - Overflow flag set on FFh to 00h
// - Overflow request equals enable and flag
// - Compare request equals enable and flag
// - External request equals enable and flag
// - Flags cleared only by writing zero
// - Capture mode copies counter, sets edge flag
// - Capture-reset mode also clears counter, prescaler
// - External-load mode loads counter on edge
// - Every counter load clears the prescaler
// - Mode bits select the four modes
// - Load strobe loads counter, reads zero
// - Count enable off freezes prescaler and counter
// - PWM enable gates PWM onto pin
// - Reset clears mode control to zero
// - Writing 06h clears only overflow flag
// - Clock source bits select clock input
// - Edge enable and polarity bits control detection
// - Prescale ratio is two to select
// - Load register write loads counter immediately
module rtp_timer
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_input_pin_i,
  output logic pwm_out_pin_o,
  output logic ovf_irq_o,
  output logic cmp_irq_o,
  output logic ext_irq_o
);

  logic [7:0] mode_control_reg;
  logic [7:0] clock_edge_prescale_reg;
  logic [7:0] reload_capture_reg;
  logic [7:0] compare_reg;
  logic [7:0] up_counter;
  logic [6:0] prescaler_counter;
  logic [1:0] div3_cnt;
  logic overflow_flag;
  logic compare_flag;
  logic edge_event_flag;
  logic pwm_state;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic pin_prev;
  logic src_tick;
  logic presc_tick;
  logic active_edge;
  logic wr_mode;
  logic wr_flags;
  logic wr_load;
  logic load_strobe;
  logic count_step;
  logic wrap;
  logic capture;
  logic ext_load;
  logic [7:0] next_counter;
  logic [7:0] tap_mask;
  rtp_pkg::rtp_mode_t mode;
  rtp_pkg::rtp_clk_t clk_sel;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  rtp_edge_det u_pin
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i(ext_input_pin_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign mode = rtp_pkg::rtp_mode_t'(mode_control_reg[1:0]);
  assign clk_sel = rtp_pkg::rtp_clk_t'(clock_edge_prescale_reg[1:0]);
  assign wr_mode = wr_i && (addr_i == `RTP_ADDR_MODE);
  assign wr_flags = wr_i && (addr_i == `RTP_ADDR_FLAGS);
  assign wr_load = wr_i && (addr_i == `RTP_ADDR_LOAD);
  assign load_strobe = wr_mode && wdata_i[`RTP_MC_LOAD];
  // Edge detection gated by enable, polarity picks falling when set.
  assign active_edge = clock_edge_prescale_reg[`RTP_CE_SL0] &&
                       (clock_edge_prescale_reg[`RTP_CE_SL1] ? pin_fall : pin_rise);
  assign capture = active_edge && ((mode == rtp_pkg::RTP_CAPTURE) || (mode == rtp_pkg::RTP_CAPTURE_RESET));
  assign ext_load = active_edge && (mode == rtp_pkg::RTP_EXT_LOAD);

  // ----------------------------------------------------------------
  // Clock source and prescaler tap
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (clk_sel)
      rtp_pkg::RTP_CLK_INT: src_tick = 1'b1;
      rtp_pkg::RTP_CLK_DIV3: src_tick = (div3_cnt == `RTP_DIV3_LAST);
      rtp_pkg::RTP_CLK_PIN: src_tick = pin_level & ~pin_prev;
      rtp_pkg::RTP_CLK_RSVD: src_tick = 1'b0;
    endcase
  end

  // The tick fires when all prescaler bits below the selected tap are set.
  assign tap_mask = 8'((16'h007F << clock_edge_prescale_reg[7:5]) >> 7);
  assign presc_tick = src_tick && ((prescaler_counter & tap_mask[6:0]) == tap_mask[6:0]);
  assign count_step = mode_control_reg[`RTP_MC_TEN] && presc_tick;
  assign wrap = count_step && (up_counter == 8'hFF);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      div3_cnt <= 2'h0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_prev <= pin_level;
      if (mode_control_reg[`RTP_MC_TEN])
      begin
        div3_cnt <= (div3_cnt == `RTP_DIV3_LAST) ? 2'h0 : div3_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and prescaler
  // ----------------------------------------------------------------
  always_comb
  begin
    next_counter = up_counter;
    if (wr_load)
    begin
      next_counter = wdata_i;
    end
    else if (load_strobe || ext_load)
    begin
      next_counter = reload_capture_reg;
    end
    else if (capture && (mode == rtp_pkg::RTP_CAPTURE_RESET))
    begin
      next_counter = 8'h00;
    end
    else if (wrap && (mode == rtp_pkg::RTP_AUTO_RELOAD))
    begin
      next_counter = reload_capture_reg;
    end
    else if (count_step)
    begin
      next_counter = up_counter + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      up_counter <= 8'h00;
      prescaler_counter <= 7'h00;
    end
    else
    begin
      up_counter <= next_counter;
      if (wr_load || load_strobe || ext_load || (capture && (mode == rtp_pkg::RTP_CAPTURE_RESET)) ||
          (wrap && (mode == rtp_pkg::RTP_AUTO_RELOAD)))
      begin
        prescaler_counter <= 7'h00;
      end
      else if (mode_control_reg[`RTP_MC_TEN] && src_tick)
      begin
        prescaler_counter <= prescaler_counter + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mode_control_reg <= `RTP_MODE_RST;
      clock_edge_prescale_reg <= `RTP_CEP_RST;
      compare_reg <= 8'hFF;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_control_reg <= {1'b0, wdata_i[6:0]};
      end
      if (wr_i && (addr_i == `RTP_ADDR_CEP))
      begin
        clock_edge_prescale_reg <= {wdata_i[7:5], 1'b0, wdata_i[3:0]};
      end
      if (wr_i && (addr_i == `RTP_ADDR_COMPARE))
      begin
        compare_reg <= wdata_i;
      end
    end
  end

  // Capture wins over a software write in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      reload_capture_reg <= 8'h00;
    end
    else if (capture)
    begin
      reload_capture_reg <= up_counter;
    end
    else if (wr_i && (addr_i == `RTP_ADDR_RELOAD))
    begin
      reload_capture_reg <= wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Status flags: set wins over a clearing write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
      edge_event_flag <= 1'b0;
    end
    else
    begin
      overflow_flag <= wrap || (overflow_flag && !(wr_flags && !wdata_i[`RTP_SF_OVF]));
      compare_flag <= (count_step && (next_counter == compare_reg)) ||
                      (compare_flag && !(wr_flags && !wdata_i[`RTP_SF_CPF]));
      edge_event_flag <= active_edge || (edge_event_flag && !(wr_flags && !wdata_i[`RTP_SF_EF]));
    end
  end

  // ----------------------------------------------------------------
  // PWM state and pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pwm_state <= 1'b0;
      pwm_out_pin_o <= 1'b0;
    end
    else
    begin
      if (count_step && (next_counter == compare_reg))
      begin
        pwm_state <= 1'b0;
      end
      else if (wrap)
      begin
        pwm_state <= 1'b1;
      end
      pwm_out_pin_o <= mode_control_reg[`RTP_MC_PWM_OUTPUT_ENABLE] && pwm_state;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt levels and read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ovf_irq_o <= 1'b0;
      cmp_irq_o <= 1'b0;
      ext_irq_o <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      ovf_irq_o <= mode_control_reg[`RTP_MC_OVERFLOW_IRQ_ENABLE] && overflow_flag;
      cmp_irq_o <= mode_control_reg[`RTP_MC_COMPARE_IRQ_ENABLE] && compare_flag;
      ext_irq_o <= mode_control_reg[`RTP_MC_EIE] && edge_event_flag;
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        unique case (addr_i)
          `RTP_ADDR_MODE: rdata_o <= mode_control_reg;
          `RTP_ADDR_FLAGS: rdata_o <= {5'h00, edge_event_flag, compare_flag, overflow_flag};
          `RTP_ADDR_CEP: rdata_o <= clock_edge_prescale_reg;
          `RTP_ADDR_RELOAD: rdata_o <= reload_capture_reg;
          `RTP_ADDR_COMPARE: rdata_o <= compare_reg;
          `RTP_ADDR_LOAD: rdata_o <= up_counter;
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_full_wrap;
    wrap && (mode == rtp_pkg::RTP_AUTO_RELOAD) && !wr_load && !load_strobe && !ext_load;
  endsequence

  property p_reload;
    @(posedge clk_i) disable iff (srst_i)
    s_full_wrap |=> (up_counter == $past(reload_capture_reg)) && (prescaler_counter == 7'h00);
  endproperty
  a_reload: assert property (p_reload) else $error("Counter not reloaded on overflow.");

  property p_ovf_set;
    @(posedge clk_i) disable iff (srst_i)
    wrap |=> overflow_flag ##1 (ovf_irq_o == mode_control_reg[`RTP_MC_OVERFLOW_IRQ_ENABLE] || $past(wr_mode));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag or request wrong.");

  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
    (!mode_control_reg[`RTP_MC_TEN] && !wr_i && !active_edge) |=> $stable(up_counter) && $stable(prescaler_counter);
  endproperty
  a_hold: assert property (p_hold) else $error("Counter moved while disabled.");

  property p_write_one;
    @(posedge clk_i) disable iff (srst_i)
    (wr_flags && wdata_i[2:0] == 3'h7 && compare_flag) |=> compare_flag;
  endproperty
  a_write_one: assert property (p_write_one) else $error("Writing one cleared a flag.");

  property p_clear_ovf_only;
    @(posedge clk_i) disable iff (srst_i)
    (wr_flags && wdata_i == 8'h06 && edge_event_flag && !wrap) |=> !overflow_flag && edge_event_flag;
  endproperty
  a_clear_ovf_only: assert property (p_clear_ovf_only) else $error("Writing 06h misbehaved.");

  property p_capture;
    @(posedge clk_i) disable iff (srst_i)
    capture |=> (reload_capture_reg == $past(up_counter)) && edge_event_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("Capture missed.");

  property p_cap_reset;
    @(posedge clk_i) disable iff (srst_i)
    (capture && mode == rtp_pkg::RTP_CAPTURE_RESET && !wr_load && !load_strobe) |=> up_counter == 8'h00;
  endproperty
  a_cap_reset: assert property (p_cap_reset) else $error("Counter not cleared on capture.");

  property p_strobe;
    @(posedge clk_i) disable iff (srst_i)
    (load_strobe && !wr_load) |=> (up_counter == $past(reload_capture_reg)) && !mode_control_reg[`RTP_MC_LOAD];
  endproperty
  a_strobe: assert property (p_strobe) else $error("Load strobe failed.");

  property p_pwm_gate;
    @(posedge clk_i) disable iff (srst_i)
    !mode_control_reg[`RTP_MC_PWM_OUTPUT_ENABLE] |=> !pwm_out_pin_o;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("PWM pin driven while disabled.");

endmodule

//--- rtp_pin_model.sv
/*
  Far-side model of the reload timer: a pulse source on the input pin and a load on the PWM pin.
  Assumes the bench pulses fire_i for one cycle and changes idle_i only while no pulse is running.
*/
module rtp_pin_model
(
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic idle_i,
  input wire logic clr_i,
  input wire logic pwm_i,
  output logic pin_o,
  output logic [7:0] high_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] hold = 3'h0;
  logic [7:0] cnt = 8'h00;

  // ----------------------------------------------------------------
  // Pulse source
  // ----------------------------------------------------------------
  // A pulse leaves the idle level for four cycles, long enough for the pin synchroniser.
  always_ff @(posedge clk_i)
  begin
    if (fire_i)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end

  assign pin_o = (hold != 3'h0) ? ~idle_i : idle_i;

  // ----------------------------------------------------------------
  // PWM load
  // ----------------------------------------------------------------
  // Counts the cycles that the PWM pin is seen high since the last clear.
  always_ff @(posedge clk_i)
  begin
    if (clr_i)
      cnt <= 8'h00;
    else if (pwm_i)
      cnt <= cnt + 8'h01;
  end

  assign high_cnt_o = cnt;
endmodule

//--- tb_top.sv
/*
  Self-checking bench of the reload timer: register bus tasks and directed tests.
  Assumes rtp_timer from the design files and the pin model in rtp_pin_model.sv.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pin;
  logic pwm;
  logic ovf_irq;
  logic cmp_irq;
  logic ext_irq;
  logic fire = 1'b0;
  logic idle = 1'b0;
  logic clr = 1'b0;
  logic [7:0] high_cnt;
  logic [3:0] sig;
  int fails = 0;
  int n_tests = 0;

  assign sig = {pwm, ext_irq, cmp_irq, ovf_irq};

  rtp_timer u_dut
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .ext_input_pin_i(pin),
    .pwm_out_pin_o(pwm),
    .ovf_irq_o(ovf_irq),
    .cmp_irq_o(cmp_irq),
    .ext_irq_o(ext_irq)
  );

  rtp_pin_model u_far
  (
    .clk_i(clk_i),
    .fire_i(fire),
    .idle_i(idle),
    .clr_i(clr),
    .pwm_i(pwm),
    .pin_o(pin),
    .high_cnt_o(high_cnt)
  );

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Bus, wait and check tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    n_tests++;
    if ((got & mask) !== (exp & mask))
    begin
      $display("wrong value at %0t: got %h expected %h mask %h", $time, got, exp, mask);
      fails++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, mask);
  endtask

  // Waits for one of the watched outputs to go high within lim cycles.
  task automatic wait_sig(input int b, input int lim);
    int i;
    for (i = 0; i < lim && sig[b] !== 1'b1; i++)
      @(posedge clk_i);
    n_tests++;
    if (sig[b] !== 1'b1)
    begin
      $display("wrong value at %0t: output %0d never rose", $time, b);
      fails++;
      end_sim();
    end
  endtask

  task automatic pulse();
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    cycles(16);
    srst_i <= 1'b0;
    rd_reg(8'hD5, 8'h00, 8'hFF);
    rd_reg(8'hD6, 8'h00, 8'h07);
    rd_reg(8'hC0, 8'h00, 8'hFF);
    $display("test reset done");

    wr_reg(8'hD9, 8'h55);
    wr_reg(8'hD5, 8'h80);
    rd_reg(8'hD5, 8'h00, 8'hFF);
    rd_reg(8'hDB, 8'h55, 8'hFF);
    $display("test load strobe done");

    // Slowest prescale steps the counter once every 128 cycles, so it steps once between the two reads.
    wr_reg(8'hD7, 8'hE0);
    wr_reg(8'hD9, 8'h40);
    wr_reg(8'hDB, 8'hFF);
    wr_reg(8'hD5, 8'h44);
    wait_sig(0, 300);
    cycles(64);
    rd_reg(8'hDB, 8'h40, 8'hFF);
    cycles(128);
    rd_reg(8'hDB, 8'h41, 8'hFF);
    rd_reg(8'hD6, 8'h01, 8'h01);
    wr_reg(8'hD6, 8'hFF);
    rd_reg(8'hD6, 8'h01, 8'h01);
    wr_reg(8'hD6, 8'h06);
    rd_reg(8'hD6, 8'h00, 8'h01);
    chk({7'h00, ovf_irq}, 8'h00, 8'h01);
    wr_reg(8'hD5, 8'h04);
    cycles(300);
    rd_reg(8'hDB, 8'h41, 8'hFF);
    $display("test overflow and flags done");

    wr_reg(8'hD7, 8'h00);
    wr_reg(8'hD9, 8'hF0);
    wr_reg(8'hDA, 8'hF8);
    wr_reg(8'hD5, 8'hE8);
    rd_reg(8'hD5, 8'h68, 8'hFF);
    wait_sig(1, 40);
    cycles(1);
    chk({7'h00, pwm}, 8'h00, 8'h01);
    wait_sig(3, 20);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    cycles(32);
    #1;
    chk(high_cnt, 8'h10, 8'hFF);
    wr_reg(8'hD6, 8'hFF);
    rd_reg(8'hD6, 8'h02, 8'h02);
    wr_reg(8'hD5, 8'h48);
    cycles(2);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    cycles(40);
    #1;
    chk(high_cnt, 8'h00, 8'hFF);
    $display("test pwm done");

    wr_reg(8'hD5, 8'h00);
    wr_reg(8'hD6, 8'h00);
    wr_reg(8'hD7, 8'hE4);
    wr_reg(8'hDB, 8'h20);
    wr_reg(8'hD5, 8'h51);
    pulse();
    wait_sig(2, 20);
    rd_reg(8'hD9, 8'h20, 8'hFF);
    rd_reg(8'hD6, 8'h04, 8'h04);
    wr_reg(8'hD6, 8'h06);
    rd_reg(8'hD6, 8'h04, 8'h05);
    wr_reg(8'hD6, 8'h03);
    rd_reg(8'hD6, 8'h00, 8'h04);
    wr_reg(8'hDB, 8'h30);
    wr_reg(8'hD5, 8'h52);
    pulse();
    wait_sig(2, 20);
    rd_reg(8'hD9, 8'h30, 8'hFF);
    rd_reg(8'hDB, 8'h00, 8'hFF);
    $display("test capture done");

    wr_reg(8'hD5, 8'h00);
    wr_reg(8'hD7, 8'hEC);
    idle <= 1'b1;
    cycles(10);
    wr_reg(8'hD9, 8'h77);
    wr_reg(8'hDB, 8'h10);
    wr_reg(8'hD5, 8'h53);
    pulse();
    rd_reg(8'hDB, 8'h77, 8'hFF);
    $display("test external load done");

    wr_reg(8'hD5, 8'h00);
    idle <= 1'b0;
    cycles(10);
    wr_reg(8'hD7, 8'h02);
    wr_reg(8'hDB, 8'h10);
    wr_reg(8'hD5, 8'h40);
    repeat (3) pulse();
    rd_reg(8'hDB, 8'h13, 8'hFF);
    $display("test pin clock done");

    wr_reg(8'hD5, 8'h00);
    wr_reg(8'hD7, 8'h01);
    wr_reg(8'hDB, 8'h00);
    wr_reg(8'hD5, 8'h40);
    // Thirty enabled edges hold exactly ten divide-by-3 ticks whatever the divider phase.
    cycles(29);
    rd_reg(8'hDB, 8'h0A, 8'hFF);
    $display("test divide by 3 done");
    end_sim();
  end
endmodule
